// ===== hdl/cpu_data_move_arith_ops.sv
`timescale 1ns/1ps
`default_nettype none
`include "dm_consts.svh"

module cpu_data_move_arith_ops
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             start_i,
	input  wire dm_pkg::op_type   op_i,
	input  wire dm_pkg::size_type size_i,
	input  wire logic             signed_i,
	input  wire logic             x_flag_i,
	input  wire logic [31:0]      src_i,
	input  wire logic [31:0]      dst_i,
	input  wire logic [31:0]      dst_hi_i,
	input  wire logic [31:0]      ea_i,
	input  wire logic [31:0]      areg_i,
	input  wire logic [31:0]      sp_i,
	input  wire logic [31:0]      disp_i,
	input  wire logic [7:0]       imm_i,
	input  wire logic [15:0]      reg_list_i,
	input  wire logic [3:0]       dst_idx_i,
	input  wire logic [3:0]       src_idx_i,
	input  wire logic [3:0]       aux_idx_i,
	input  wire logic             mem_ack_i,
	input  wire logic [31:0]      mem_rdata_i,
	input  wire logic [31:0]      regrd_data_i,
	output logic                  busy_o,
	output logic                  done_o,
	output logic                  illegal_o,
	output logic                  div_zero_o,
	output logic                  overflow_o,
	output logic                  wb0_en_o,
	output logic [3:0]            wb0_idx_o,
	output logic [31:0]           wb0_data_o,
	output logic                  wb1_en_o,
	output logic [3:0]            wb1_idx_o,
	output logic [31:0]           wb1_data_o,
	output logic                  mem_req_o,
	output logic                  mem_we_o,
	output dm_pkg::size_type      mem_size_o,
	output logic [31:0]           mem_addr_o,
	output logic [31:0]           mem_wdata_o,
	output logic [3:0]            regrd_idx_o
);
	import dm_pkg::*;

	function automatic logic [31:0] sx16(input logic [31:0] v);
		sx16 = {{16{v[15]}}, v[15:0]};
	endfunction

	function automatic logic [31:0] merge(input size_type sz,
		input logic [31:0] d, input logic [31:0] r);
		merge = (sz == SZ_BYTE) ? {d[31:8], r[7:0]} :
			(sz == SZ_WORD) ? {d[31:16], r[15:0]} : r;
	endfunction

	function automatic logic [3:0] lowest(input logic [15:0] l);
		lowest = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (l[i])
				lowest = 4'(i);
	endfunction

	state_type   state_ff, nxt_state;
	op_type      op_ff;
	size_type    size_ff, nxt_msize;
	logic [4:0]  step_ff, nxt_step;
	logic [31:0] data_ff, nxt_data, aux_ff;
	logic [15:0] list_ff, nxt_list;
	logic [3:0]  cur_idx_ff, nxt_cur_idx, dst_idx_ff, aux_idx_ff;
	logic        neg_q_ff, neg_r_ff, signed_ff, div_start_ff, nxt_div_start;
	logic        nxt_done, nxt_ill, nxt_dz, nxt_ovf, nxt_wb0_en, nxt_wb1_en;
	logic [3:0]  nxt_wb0_idx, nxt_wb1_idx, nxt_rdidx;
	logic [31:0] nxt_wb0_data, nxt_wb1_data, nxt_maddr, nxt_wdata;
	logic        nxt_req, nxt_we;
	logic [31:0] alu_res;
	logic        alu_wr;
	logic        div_done;
	logic [63:0] quo, rem, dd_ff, dv_ff;

	// ****************************************************************
	// operand decode
	// ****************************************************************
	wire logic take = start_i && state_ff == ST_IDLE;
	wire logic addr_op = op_i inside {OP_ADDA, OP_SUBA, OP_CMPA, OP_ALOAD,
		OP_MM_ST, OP_MM_LD, OP_MP_ST, OP_MP_LD, OP_MUL, OP_MUL64,
		OP_DIV, OP_DIV64};
	wire logic size_bad = (size_i == SZ_BYTE) ? addr_op :
		(size_i != SZ_WORD && size_i != SZ_LONG);
	wire logic x_in = x_flag_i && op_i inside {OP_CARRY_IN_SUM, OP_BORROW_IN_DIFFERENCE, OP_BORROW_IN_NEGATION};
	wire logic [31:0] src_a = (size_i == SZ_WORD) ? sx16(src_i) : src_i;
	wire logic [31:0] disp_x = (size_i == SZ_WORD) ? sx16(disp_i) : disp_i;
	wire logic [31:0] sp_dec = sp_i - `STACK_STEP;
	wire logic [31:0] mp_base = areg_i + sx16(disp_i);
	wire logic [31:0] mp_first = (size_i == SZ_WORD) ?
		{src_i[15:0], 16'h0000} : src_i;
	wire logic [4:0] mp_last = (size_ff == SZ_WORD) ?
		`PERIPH_LAST_WORD : `PERIPH_LAST_LONG;
	wire logic [31:0] mm_step = (size_ff == SZ_WORD) ?
		`BLOCK_STEP_WORD : `BLOCK_STEP_LONG;

	// ****************************************************************
	// single-cycle arithmetic
	// ****************************************************************
	wire logic [31:0] sum = dst_i + src_i + {31'h0, x_in};
	wire logic [31:0] dif = dst_i - src_i - {31'h0, x_in};
	wire logic [31:0] ngt = 32'h0000_0000 - dst_i - {31'h0, x_in};
	wire logic [31:0] sign_widen = (size_i == SZ_BYTE) ? {{24{dst_i[7]}}, dst_i[7:0]} :
		(size_i == SZ_WORD) ? {dst_i[31:16], {8{dst_i[7]}}, dst_i[7:0]} :
		sx16(dst_i);
	// 33-bit signed operands let one multiplier serve both signednesses
	wire logic [32:0] mul_a = (size_i == SZ_WORD) ?
		{{17{signed_i & src_i[15]}}, src_i[15:0]} : {signed_i & src_i[31], src_i};
	wire logic [32:0] mul_b = (size_i == SZ_WORD) ?
		{{17{signed_i & dst_i[15]}}, dst_i[15:0]} : {signed_i & dst_i[31], dst_i};
	wire logic [65:0] mul_full = $signed(mul_a) * $signed(mul_b);
	wire logic [63:0] mul_p = mul_full[63:0];
	wire logic mul_ovf = (size_i == SZ_LONG) && (signed_i ?
		(mul_p[63:31] != {33{mul_p[31]}}) : (mul_p[63:32] != 32'h0));

	always_comb
	begin
		alu_wr  = 1'b1;
		alu_res = 32'h0000_0000;
		unique case (op_i)
			OP_QUICK: alu_res = {{24{imm_i[7]}}, imm_i};
			OP_SWAP:  alu_res = src_i;
			OP_LEA:   alu_res = ea_i;
			OP_ALOAD: alu_res = src_a;
			OP_ADD, OP_CARRY_IN_SUM: alu_res = merge(size_i, dst_i, sum);
			OP_SUB, OP_BORROW_IN_DIFFERENCE: alu_res = merge(size_i, dst_i, dif);
			OP_CMP:
			begin
				alu_wr  = 1'b0;
				alu_res = merge(size_i, dst_i, dif);
			end
			OP_ADDA:  alu_res = dst_i + src_a;
			OP_SUBA:  alu_res = dst_i - src_a;
			OP_CMPA:
			begin
				alu_wr  = 1'b0;
				alu_res = dst_i - src_a;
			end
			OP_NEG, OP_BORROW_IN_NEGATION: alu_res = merge(size_i, dst_i, ngt);
			OP_CLR:   alu_res = merge(size_i, dst_i, 32'h0);
			OP_EXT:   alu_res = sign_widen;
			OP_MUL, OP_MUL64: alu_res = mul_p[31:0];
			default:  alu_wr = 1'b0;
		endcase
	end

	// ****************************************************************
	// division operands and result
	// ****************************************************************
	wire logic [63:0] dd = (op_i == OP_DIV64) ? {dst_hi_i, dst_i} :
		{{32{signed_i & dst_i[31]}}, dst_i};
	wire logic [63:0] dv = (size_i == SZ_WORD) ?
		{{48{signed_i & src_i[15]}}, src_i[15:0]} :
		{{32{signed_i & src_i[31]}}, src_i};
	wire logic neg_dd = signed_i & dd[63];
	wire logic neg_dv = signed_i & dv[63];
	wire logic [63:0] dd_abs = neg_dd ? 64'h0 - dd : dd;
	wire logic [63:0] dv_abs = neg_dv ? 64'h0 - dv : dv;
	wire logic [63:0] q_s = neg_q_ff ? 64'h0 - quo : quo;
	wire logic [63:0] r_s = neg_r_ff ? 64'h0 - rem : rem;
	// quotient that does not fit leaves the destination untouched
	wire logic div_ovf = (size_ff == SZ_WORD) ?
		(signed_ff ? q_s[63:15] != {49{q_s[15]}} : q_s[63:16] != 48'h0) :
		(signed_ff ? q_s[63:31] != {33{q_s[31]}} : q_s[63:32] != 32'h0);

	seq_divider #(.W(`DIV_WIDTH)) u_div (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.start_i    (div_start_ff),
		.dividend_i (dd_ff),
		.divisor_i  (dv_ff),
		.done_o     (div_done),
		.quo_o      (quo),
		.rem_o      (rem)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb
	begin
		nxt_state = state_ff;
		nxt_step = step_ff;
		nxt_data = data_ff;
		nxt_list = list_ff;
		nxt_cur_idx = cur_idx_ff;
		nxt_div_start = 1'b0;
		nxt_done = 1'b0;
		nxt_ill = 1'b0;
		nxt_dz = 1'b0;
		nxt_ovf = 1'b0;
		nxt_wb0_en = 1'b0;
		nxt_wb1_en = 1'b0;
		nxt_wb0_idx = wb0_idx_o;
		nxt_wb1_idx = wb1_idx_o;
		nxt_wb0_data = wb0_data_o;
		nxt_wb1_data = wb1_data_o;
		nxt_req = mem_req_o;
		nxt_we = mem_we_o;
		nxt_msize = mem_size_o;
		nxt_maddr = mem_addr_o;
		nxt_wdata = mem_wdata_o;
		nxt_rdidx = regrd_idx_o;
		unique case (state_ff)
			ST_IDLE:
				if (take && size_bad)
				begin
					nxt_ill = 1'b1;
					nxt_done = 1'b1;
				end
				else if (take)
					unique case (op_i)
						OP_PEA, OP_LINK, OP_UNLINK:
						begin
							nxt_req = 1'b1;
							nxt_we = op_i != OP_UNLINK;
							nxt_msize = SZ_LONG;
							nxt_maddr = (op_i == OP_UNLINK) ? areg_i : sp_dec;
							nxt_wdata = (op_i == OP_PEA) ? ea_i : areg_i;
							nxt_state = ST_MEM;
						end
						OP_MP_ST, OP_MP_LD:
						begin
							nxt_req = 1'b1;
							nxt_we = op_i == OP_MP_ST;
							nxt_msize = SZ_BYTE;
							nxt_maddr = mp_base;
							nxt_wdata = {24'h0, mp_first[31:24]};
							nxt_data = mp_first;
							nxt_step = 5'h00;
							nxt_state = ST_MEM;
						end
						OP_MM_ST, OP_MM_LD:
						begin
							nxt_list = reg_list_i;
							nxt_maddr = ea_i;
							nxt_msize = size_i;
							nxt_we = op_i == OP_MM_ST;
							nxt_state = ST_SCAN;
						end
						OP_DIV, OP_DIV64:
							if (dv_abs == 64'h0)
							begin
								nxt_dz = 1'b1;
								nxt_done = 1'b1;
							end
							else
							begin
								nxt_div_start = 1'b1;
								nxt_state = ST_DIV;
							end
						default:
						begin
							nxt_done = 1'b1;
							nxt_wb0_en = alu_wr;
							nxt_wb0_idx = dst_idx_i;
							nxt_wb0_data = alu_res;
							nxt_wb1_en = op_i == OP_SWAP || op_i == OP_MUL64;
							nxt_wb1_idx = (op_i == OP_SWAP) ? src_idx_i : aux_idx_i;
							nxt_wb1_data = (op_i == OP_SWAP) ? dst_i : mul_p[63:32];
							nxt_ovf = op_i == OP_MUL && mul_ovf;
						end
					endcase
			ST_SCAN:
				if (list_ff == 16'h0)
				begin
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
				else
				begin
					nxt_list = list_ff & (list_ff - 16'h1);
					nxt_cur_idx = lowest(list_ff);
					nxt_rdidx = lowest(list_ff);
					nxt_req = ~mem_we_o;
					nxt_state = mem_we_o ? ST_RDREG : ST_MEM;
				end
			ST_RDREG:
			begin
				nxt_req = 1'b1;
				nxt_wdata = regrd_data_i;
				nxt_state = ST_MEM;
			end
			ST_MEM:
				if (mem_ack_i)
				begin
					nxt_req = 1'b0;
					nxt_state = ST_IDLE;
					unique case (op_ff)
						OP_PEA:
						begin
							nxt_done = 1'b1;
							nxt_wb1_en = 1'b1;
							nxt_wb1_idx = `SP_IDX;
							nxt_wb1_data = mem_addr_o;
						end
						OP_LINK:
						begin
							nxt_done = 1'b1;
							nxt_wb0_en = 1'b1;
							nxt_wb0_idx = dst_idx_ff;
							nxt_wb0_data = mem_addr_o;
							nxt_wb1_en = 1'b1;
							nxt_wb1_idx = `SP_IDX;
							nxt_wb1_data = mem_addr_o + aux_ff;
						end
						OP_UNLINK:
						begin
							nxt_done = 1'b1;
							nxt_wb0_en = 1'b1;
							nxt_wb0_idx = dst_idx_ff;
							nxt_wb0_data = mem_rdata_i;
							nxt_wb1_en = 1'b1;
							nxt_wb1_idx = `SP_IDX;
							nxt_wb1_data = aux_ff + `STACK_STEP;
						end
						OP_MP_ST, OP_MP_LD:
						begin
							nxt_data = {data_ff[23:0], mem_rdata_i[7:0]};
							if (step_ff == mp_last)
							begin
								nxt_done = 1'b1;
								nxt_wb0_en = op_ff == OP_MP_LD;
								nxt_wb0_idx = dst_idx_ff;
								nxt_wb0_data = (size_ff == SZ_WORD) ?
									{aux_ff[31:16], nxt_data[15:0]} : nxt_data;
							end
							else
							begin
								nxt_step = step_ff + 5'h01;
								nxt_maddr = mem_addr_o + `PERIPH_STEP;
								nxt_wdata = {24'h0, data_ff[23:16]};
								nxt_req = 1'b1;
								nxt_state = ST_MEM;
							end
						end
						OP_MM_ST, OP_MM_LD:
						begin
							nxt_maddr = mem_addr_o + mm_step;
							nxt_state = ST_SCAN;
							nxt_wb0_en = op_ff == OP_MM_LD;
							nxt_wb0_idx = cur_idx_ff;
							nxt_wb0_data = (size_ff == SZ_WORD) ?
								sx16(mem_rdata_i) : mem_rdata_i;
						end
						default:
							nxt_done = 1'b1;
					endcase
				end
			ST_DIV:
				if (div_done)
				begin
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
					nxt_ovf = div_ovf;
					nxt_wb0_en = ~div_ovf;
					nxt_wb0_idx = dst_idx_ff;
					nxt_wb0_data = (size_ff == SZ_WORD) ?
						{r_s[15:0], q_s[15:0]} : q_s[31:0];
					nxt_wb1_en = ~div_ovf && size_ff == SZ_LONG;
					nxt_wb1_idx = aux_idx_ff;
					nxt_wb1_data = r_s[31:0];
				end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// command fields stay fixed for the whole multi-cycle operation
	always_ff @(posedge clk_i)
		if (take)
		begin
			op_ff <= op_i;
			size_ff <= size_i;
			signed_ff <= signed_i;
			dst_idx_ff <= dst_idx_i;
			aux_idx_ff <= aux_idx_i;
			neg_q_ff <= neg_dd ^ neg_dv;
			neg_r_ff <= neg_dd;
			// divider loads a cycle after take, when operands may have moved
			dd_ff <= dd_abs;
			dv_ff <= dv_abs;
			aux_ff <= (op_i == OP_UNLINK) ? areg_i :
				(op_i == OP_LINK) ? disp_x : dst_i;
		end

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			state_ff <= ST_IDLE;
			{step_ff, data_ff, list_ff, cur_idx_ff, div_start_ff} <= '0;
			{busy_o, done_o, illegal_o, div_zero_o, overflow_o} <= '0;
			{wb0_en_o, wb0_idx_o, wb0_data_o} <= '0;
			{wb1_en_o, wb1_idx_o, wb1_data_o} <= '0;
			{mem_req_o, mem_we_o, mem_addr_o, mem_wdata_o, regrd_idx_o} <= '0;
			mem_size_o <= SZ_LONG;
		end
		else
		begin
			state_ff <= nxt_state;
			{step_ff, data_ff, list_ff, cur_idx_ff} <=
				{nxt_step, nxt_data, nxt_list, nxt_cur_idx};
			div_start_ff <= nxt_div_start;
			busy_o <= nxt_state != ST_IDLE;
			{done_o, illegal_o, div_zero_o, overflow_o} <=
				{nxt_done, nxt_ill, nxt_dz, nxt_ovf};
			{wb0_en_o, wb0_idx_o, wb0_data_o} <=
				{nxt_wb0_en, nxt_wb0_idx, nxt_wb0_data};
			{wb1_en_o, wb1_idx_o, wb1_data_o} <=
				{nxt_wb1_en, nxt_wb1_idx, nxt_wb1_data};
			{mem_req_o, mem_we_o, mem_addr_o, mem_wdata_o, regrd_idx_o} <=
				{nxt_req, nxt_we, nxt_maddr, nxt_wdata, nxt_rdidx};
			mem_size_o <= nxt_msize;
		end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wire logic ok = take && !size_bad;

	sequence s_link_go;
		ok && op_i == OP_LINK;
	endsequence
	sequence s_link_push;
		mem_req_o && mem_we_o && mem_addr_o == $past(sp_i) - `STACK_STEP
			&& mem_wdata_o == $past(areg_i);
	endsequence

	a_quick_load:
	assert property (ok && op_i == OP_QUICK |=> wb0_en_o && done_o
		&& wb0_data_o == {{24{$past(imm_i[7])}}, $past(imm_i)})
	else $error("quick load not sign-widened");
	a_swap_pair:
	assert property (ok && op_i == OP_SWAP |=> wb0_en_o && wb1_en_o
		&& wb0_data_o == $past(src_i) && wb1_data_o == $past(dst_i))
	else $error("swap not exchanged");
	a_lea_nomem:
	assert property (ok && op_i == OP_LEA |=> !mem_req_o
		&& wb0_data_o == $past(ea_i))
	else $error("address load wrong");
	a_push_addr:
	assert property (ok && op_i == OP_PEA |=> mem_req_o && mem_we_o
		&& mem_addr_o == $past(sp_i) - `STACK_STEP && mem_wdata_o == $past(ea_i))
	else $error("push address wrong");
	a_link_push:
	assert property (s_link_go |=> s_link_push)
	else $error("frame push wrong");
	a_unlink_pop:
	assert property (ok && op_i == OP_UNLINK |=> mem_req_o && !mem_we_o
		&& mem_addr_o == $past(areg_i))
	else $error("frame pop address wrong");
	a_addr_byte:
	assert property (take && addr_op && size_i == SZ_BYTE |=> illegal_o
		&& done_o && !wb0_en_o && !mem_req_o)
	else $error("byte address operand accepted");
	a_mul_word:
	assert property (ok && op_i == OP_MUL && size_i == SZ_WORD && !signed_i
		|=> wb0_data_o == $past(src_i[15:0]) * $past(dst_i[15:0]))
	else $error("word product wrong");
	a_peripheral_byte_transfer_first:
	assert property (ok && op_i == OP_MP_ST && size_i == SZ_LONG
		|=> mem_addr_o == $past(mp_base) && mem_wdata_o[7:0] == $past(src_i[31:24]))
	else $error("peripheral first byte wrong");
	a_peripheral_byte_transfer_step:
	assert property (state_ff == ST_MEM && mem_ack_i && step_ff != mp_last
		&& op_ff inside {OP_MP_ST, OP_MP_LD}
		|=> mem_req_o && mem_addr_o == $past(mem_addr_o) + `PERIPH_STEP)
	else $error("peripheral stride wrong");
	a_clr_byte:
	assert property (ok && op_i == OP_CLR && size_i == SZ_BYTE
		|=> wb0_data_o[7:0] == 8'h00 && wb0_data_o[31:8] == $past(dst_i[31:8]))
	else $error("byte clear wrong");
	a_carry_sum:
	assert property (ok && op_i == OP_CARRY_IN_SUM && size_i == SZ_LONG |=> wb0_data_o
		== $past(dst_i) + $past(src_i) + {31'h0, $past(x_flag_i)})
	else $error("carry-in sum wrong");
	a_div_bound:
	assert property (ok && op_i inside {OP_DIV, OP_DIV64} |-> ##[1:70] done_o)
	else $error("divide did not finish");
endmodule
`default_nettype wire

// ===== hdl/dm_consts.svh
`ifndef DM_CONSTS_SVH
`define DM_CONSTS_SVH

`define SP_IDX       4'hF
`define STACK_STEP   32'h0000_0004
`define PERIPH_STEP  32'h0000_0002
`define PERIPH_LAST_LONG 5'h03
`define PERIPH_LAST_WORD 5'h01
`define BLOCK_STEP_WORD  32'h0000_0002
`define BLOCK_STEP_LONG  32'h0000_0004
`define DIV_WIDTH    64
`endif

// ===== hdl/dm_pkg.sv
package dm_pkg;
	typedef enum logic [4:0] {
		OP_QUICK, OP_SWAP, OP_LEA, OP_PEA, OP_LINK, OP_UNLINK, OP_ALOAD,
		OP_MM_ST, OP_MM_LD, OP_MP_ST, OP_MP_LD, OP_ADD, OP_SUB, OP_CMP,
		OP_ADDA, OP_SUBA, OP_CMPA, OP_CARRY_IN_SUM, OP_BORROW_IN_DIFFERENCE, OP_BORROW_IN_NEGATION, OP_CLR,
		OP_NEG, OP_EXT, OP_MUL, OP_MUL64, OP_DIV, OP_DIV64
	} op_type;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SCAN, ST_RDREG, ST_MEM, ST_DIV
	} state_type;
endpackage

// ===== hdl/seq_divider.sv
`timescale 1ns/1ps
`default_nettype none

module seq_divider
#(
	parameter int W = 64
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         start_i,
	input  wire logic [W-1:0] dividend_i,
	input  wire logic [W-1:0] divisor_i,
	output logic              done_o,
	output logic [W-1:0]      quo_o,
	output logic [W-1:0]      rem_o
);
	localparam int CW = $clog2(W + 1);

	generate
		if (W < 2)
			$error("seq_divider: W must be at least 2");
	endgenerate

	logic [CW-1:0] cnt_ff;
	logic          run_ff;
	logic [W-1:0]  dsr_ff;

	// restoring step: one quotient bit per clock, msb first
	wire logic [W:0] trial = {rem_o, quo_o[W-1]} - {1'b0, dsr_ff};

	always_ff @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (rst_i)
		begin
			run_ff <= 1'b0;
			cnt_ff <= '0;
			quo_o  <= '0;
			rem_o  <= '0;
			dsr_ff <= '0;
		end
		else if (start_i)
		begin
			quo_o  <= dividend_i;
			rem_o  <= '0;
			dsr_ff <= divisor_i;
			cnt_ff <= CW'(W);
			run_ff <= 1'b1;
		end
		else if (run_ff)
		begin
			quo_o  <= {quo_o[W-2:0], ~trial[W]};
			rem_o  <= trial[W] ? {rem_o[W-2:0], quo_o[W-1]} : trial[W-1:0];
			cnt_ff <= cnt_ff - CW'(1);
			if (cnt_ff == CW'(1))
			begin
				run_ff <= 1'b0;
				done_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/cpu_data_move_arith_ops_bench.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_data_move_arith_ops_bench;
	import dm_pkg::*;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             start_i = 1'b0;
	logic             signed_i = 1'b0;
	logic             x_flag_i = 1'b0;
	logic             mem_ack_i = 1'b0;
	op_type           op_i = OP_QUICK;
	size_type         size_i = SZ_LONG;
	logic [31:0]      src_i = '0, dst_i = '0, dst_hi_i = '0, ea_i = '0;
	logic [31:0]      areg_i = '0, sp_i = '0, disp_i = '0;
	logic [7:0]       imm_i = '0;
	logic [15:0]      reg_list_i = '0;
	logic [3:0]       dst_idx_i = 4'hB, src_idx_i = 4'h9, aux_idx_i = 4'h5;
	wire logic [31:0] mem_rdata_i, regrd_data_i;
	logic             busy_o, done_o, illegal_o, div_zero_o, overflow_o;
	logic             wb0_en_o, wb1_en_o, mem_req_o, mem_we_o;
	logic [3:0]       wb0_idx_o, wb1_idx_o, regrd_idx_o;
	logic [31:0]      wb0_data_o, wb1_data_o, mem_addr_o, mem_wdata_o;
	size_type         mem_size_o;
	int               num_errors = 0, num_checks = 0, cycles = 0;
	logic [2:0]       flags = '0;
	logic             busy_seen = 1'b0;
	logic [35:0]      wq0[$], wq1[$];
	logic [64:0]      mq[$];

	// read data depends on address so a wrong address shows in the data
	assign mem_rdata_i = mem_addr_o ^ 32'hF000_8000;
	assign regrd_data_i = {28'hA5A50C0, regrd_idx_o};

	always #2.5 clk_i = ~clk_i;

	cpu_data_move_arith_ops u_dut (.*);

	// ************************************************
	// memory responder and write-back log
	// ************************************************
	always @(negedge clk_i)
	begin
		mem_ack_i <= mem_req_o & ~mem_ack_i;
		if (mem_req_o & ~mem_ack_i)
			mq.push_back({mem_we_o, mem_addr_o, mem_wdata_o});
		if (wb0_en_o)
			wq0.push_back({wb0_idx_o, wb0_data_o});
		if (wb1_en_o)
			wq1.push_back({wb1_idx_o, wb1_data_o});
	end

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(string nm, logic [64:0] e, logic [64:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one extra edge after done so the log has caught the last pulses
	task automatic run(output logic ill);
		int n;
		wq0.delete();
		wq1.delete();
		mq.delete();
		start_i = 1'b1;
		@(negedge clk_i);
		start_i = 1'b0;
		busy_seen = busy_o;
		n = 0;
		while (done_o !== 1'b1 && n < 200)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n == 200)
			num_errors++;
		flags = {illegal_o, div_zero_o, overflow_o};
		ill = illegal_o;
		@(negedge clk_i);
	endtask

	task automatic alu(op_type o, size_type s, logic sg, logic x,
		logic [31:0] a, logic [31:0] d, logic [31:0] h, logic [31:0] e0,
		logic [31:0] e1);
		logic ill;
		op_i = o;
		size_i = s;
		signed_i = sg;
		x_flag_i = x;
		src_i = a;
		dst_i = d;
		dst_hi_i = h;
		imm_i = a[7:0];
		run(ill);
		chk(o.name(), {4'hB, e0}, wq0[0]);
		if (o == OP_MUL64 || o == OP_DIV64)
			chk("wb1", {4'h5, e1}, wq1[0]);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic moves();
		logic ill;
		src_i = 32'h1111_1111;
		dst_i = 32'h2222_2222;
		op_i = OP_SWAP;
		run(ill);
		chk("swap0", {4'hB, 32'h1111_1111}, wq0[0]);
		chk("swap1", {4'h9, 32'h2222_2222}, wq1[0]);
		ea_i = 32'hABCD_0000;
		op_i = OP_LEA;
		run(ill);
		chk("lea", {4'hB, 32'hABCD_0000}, wq0[0]);
		chk("lea mem", 32'h0, mq.size());
		sp_i = 32'h0000_2000;
		op_i = OP_PEA;
		run(ill);
		chk("push mem", {1'b1, 32'h0000_1FFC, 32'hABCD_0000}, mq[0]);
		chk("push sp", {4'hF, 32'h0000_1FFC}, wq1[0]);
		areg_i = 32'h5555_6666;
		disp_i = 32'h0000_FFF0;
		size_i = SZ_WORD;
		op_i = OP_LINK;
		run(ill);
		chk("link mem", {1'b1, 32'h0000_1FFC, 32'h5555_6666}, mq[0]);
		chk("link reg", {4'hB, 32'h0000_1FFC}, wq0[0]);
		chk("link sp", {4'hF, 32'h0000_1FEC}, wq1[0]);
		areg_i = 32'h0000_3000;
		op_i = OP_UNLINK;
		run(ill);
		chk("unlink mem", 1'b0, mq[0][64]);
		chk("unlink reg", {4'hB, 32'hF000_B000}, wq0[0]);
		chk("unlink sp", {4'hF, 32'h0000_3004}, wq1[0]);
	endtask

	task automatic transfers();
		logic ill;
		areg_i = 32'h0000_4000;
		disp_i = 32'h0;
		src_i = 32'hA1B2_C3D4;
		dst_i = 32'hA1B2_C3D4;
		size_i = SZ_LONG;
		op_i = OP_MP_ST;
		run(ill);
		for (int i = 0; i < 4; i++)
			chk("periph", {1'b1, 32'(32'h4000 + 2 * i),
				8'(8'hA1 + 8'h11 * i)}, {mq[i][64:32], mq[i][7:0]});
		chk("periph size", SZ_BYTE, mem_size_o);
		reg_list_i = 16'h0208;
		ea_i = 32'h0000_5000;
		size_i = SZ_WORD;
		op_i = OP_MM_LD;
		run(ill);
		chk("blk ld0", {4'h3, 32'hFFFF_D000}, wq0[0]);
		chk("blk ld1", {4'h9, 32'hFFFF_D002}, wq0[1]);
		chk("blk addr", {1'b0, 32'h0000_5002}, mq[1][64:32]);
		reg_list_i = 16'h0008;
		op_i = OP_MM_ST;
		run(ill);
		chk("blk st", {1'b1, 32'h0000_5000, 16'h0C03},
			{mq[0][64:32], mq[0][15:0]});
		chk("blk busy", {1'b1, 4'h3}, {busy_seen, regrd_idx_o});
		dst_i = 32'h1234_5678;
		op_i = OP_MP_LD;
		run(ill);
		chk("periph ld", {4'hB, 32'h1234_0002}, wq0[0]);
	endtask

	task automatic faults();
		logic ill;
		size_i = SZ_WORD;
		signed_i = 1'b0;
		src_i = 32'h0;
		dst_i = 32'h0001_0000;
		op_i = OP_DIV;
		run(ill);
		chk("div zero", {3'b010, 32'h0}, {flags, wq0.size()});
		src_i = 32'h1;
		run(ill);
		chk("div ovf", {3'b001, 32'h0}, {flags, wq0.size()});
		size_i = SZ_LONG;
		src_i = 32'hFFFF_FFFF;
		dst_i = 32'h2;
		op_i = OP_MUL;
		run(ill);
		chk("mul ovf", 3'b001, flags);
		src_i = 32'h1;
		op_i = OP_CMP;
		run(ill);
		chk("cmp", {32'h0, 32'h1}, {wq0.size(), wb0_data_o});
	endtask

	task automatic refusals();
		logic ill;
		op_type aops[4] = '{OP_ADDA, OP_SUBA, OP_CMPA, OP_ALOAD};
		size_i = SZ_BYTE;
		foreach (aops[i])
		begin
			op_i = aops[i];
			run(ill);
			chk("byte addr op", {1'b1, 32'h0}, {ill, wq0.size()});
		end
	endtask

	initial
	begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		alu(OP_QUICK, SZ_LONG, 0, 0, 32'h80, 0, 0, 32'hFFFF_FF80, 0);
		alu(OP_QUICK, SZ_LONG, 0, 0, 32'h7F, 0, 0, 32'h0000_007F, 0);
		moves();
		transfers();
		refusals();
		faults();
		alu(OP_ADDA, SZ_WORD, 0, 0, 32'hFFFE, 32'h1000, 0, 32'hFFE, 0);
		alu(OP_ALOAD, SZ_WORD, 0, 0, 32'h8000, 0, 0, 32'hFFFF_8000, 0);
		alu(OP_ADD, SZ_BYTE, 0, 0, 1, 32'h1234_56FF, 0, 32'h1234_5600, 0);
		alu(OP_SUB, SZ_LONG, 0, 0, 1, 32'h10, 0, 32'hF, 0);
		alu(OP_CLR, SZ_BYTE, 0, 0, 0, 32'h1234_5680, 0, 32'h1234_5600, 0);
		alu(OP_CLR, SZ_WORD, 0, 0, 0, 32'h1234_5680, 0, 32'h1234_0000, 0);
		alu(OP_CLR, SZ_LONG, 0, 0, 0, 32'h1234_5680, 0, 32'h0, 0);
		alu(OP_NEG, SZ_BYTE, 0, 0, 0, 32'h1234_5680, 0, 32'h1234_5680, 0);
		alu(OP_NEG, SZ_WORD, 0, 0, 0, 32'h1234_5680, 0, 32'h1234_A980, 0);
		alu(OP_NEG, SZ_LONG, 0, 0, 0, 32'h1234_5680, 0, 32'hEDCB_A980, 0);
		alu(OP_CARRY_IN_SUM, SZ_LONG, 0, 1, 1, 2, 0, 32'h4, 0);
		alu(OP_BORROW_IN_DIFFERENCE, SZ_LONG, 0, 1, 1, 32'h10, 0, 32'hE, 0);
		alu(OP_BORROW_IN_NEGATION, SZ_LONG, 0, 1, 0, 1, 0, 32'hFFFF_FFFE, 0);
		alu(OP_EXT, SZ_BYTE, 0, 0, 0, 32'h1234_5680, 0, 32'hFFFF_FF80, 0);
		alu(OP_EXT, SZ_WORD, 0, 0, 0, 32'h1234_5680, 0, 32'h1234_FF80, 0);
		alu(OP_EXT, SZ_LONG, 0, 0, 0, 32'h0000_8000, 0, 32'hFFFF_8000, 0);
		alu(OP_MUL, SZ_WORD, 1, 0, 32'hFFFF, 2, 0, 32'hFFFF_FFFE, 0);
		alu(OP_MUL, SZ_WORD, 0, 0, 32'hFFFF, 2, 0, 32'h0001_FFFE, 0);
		alu(OP_MUL, SZ_LONG, 0, 0, 32'h10000, 3, 0, 32'h0003_0000, 0);
		alu(OP_MUL64, SZ_LONG, 0, 0, 32'hFFFF_FFFF, 2, 0, 32'hFFFF_FFFE, 1);
		alu(OP_MUL64, SZ_LONG, 1, 0, 32'hFFFF_FFFF, 2, 0, 32'hFFFF_FFFE,
			32'hFFFF_FFFF);
		alu(OP_DIV, SZ_WORD, 0, 0, 7, 32'h64, 0, 32'h0002_000E, 0);
		alu(OP_DIV, SZ_WORD, 1, 0, 32'hFFFF_FFF9, 32'h64, 0, 32'h0002_FFF2,
			0);
		alu(OP_DIV64, SZ_LONG, 0, 0, 2, 0, 1, 32'h8000_0000, 0);
		alu(OP_DIV64, SZ_LONG, 1, 0, 32'hFFFF_FFFD, 32'h7, 0, 32'hFFFF_FFFE,
			32'h1);
		summarize();
	end
endmodule

`default_nettype wire
